/* hdl/mci_clk_div.sv */
// Common clock-enable divider for processor, serial bit clock and timer
module mci_clk_div import mci_pkg::*; #(
  parameter int unsigned CNT_W = 7
)(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // Control
  input  wire logic                 slow,
  input  wire logic [MCI_DIV_W-1:0] div_code,
  // Enables
  output logic                      tick,
  output logic                      half
);

  if (CNT_W < 7) begin : g_chk
    $error("mci_clk_div: CNT_W must hold a count of 128");
  end

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] last;

  // Divisor code 1..4 selects 16, 32, 64, 128; code 0 is undivided
  function automatic logic [CNT_W-1:0] div_last(input logic [MCI_DIV_W-1:0] code);
    logic [CNT_W-1:0] r;
    r = '0;
    if (code != MCI_DIV_NONE && code <= MCI_DIV_MAX) begin
      r = CNT_W'((16 << (code - 3'h1)) - 1);
    end
    return r;
  endfunction

  assign last     = slow ? div_last(div_code) : '0;
  assign tick     = (cnt >= last);
  assign next_cnt = tick ? '0 : cnt + 1'b1;

  // Counter restarts on each tick; half toggles so the cycle clock shows the rate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= '0;
      half <= 1'b0;
    end else begin
      cnt <= next_cnt;
      if (tick) begin
        half <= ~half;
      end
    end
  end

endmodule // mci_clk_div

/* hdl/mci_int_lowpower.sv */
// The implementer's own choices: the APB slave port and the register offsets.
module mci_int_lowpower import mci_pkg::*; #(
  parameter int unsigned WAKE_CYCLES = MCI_PD_RECOVER_CYCLES
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // External interrupt pins, active low
  input  wire logic        ext_int_selectable_n,
  input  wire logic        ext_int_level_high_n,
  input  wire logic        ext_int_level_low_n,
  input  wire logic        ext_int_edge_n,
  input  wire logic        serial_shared_int_b_n,
  input  wire logic        serial_shared_int_a_n,
  // Flag drive of the shared pins, bit 0 is flag 4
  input  wire logic [3:0]  prog_flag_pins_out,
  input  wire logic [3:0]  prog_flag_pins_oe,
  // Internal request pulses
  input  wire logic        sp1_tx_req,
  input  wire logic        sp1_rx_req,
  input  wire logic        sp2_tx_req,
  input  wire logic        sp2_rx_req,
  input  wire logic        byte_memory_transfer_req,
  input  wire logic        timer_req,
  input  wire logic        pd_int_req,
  input  wire logic        pd_wake,
  // Core side
  output logic             irq_valid,
  output logic [15:0]      irq_vector,
  input  wire logic        irq_ack,
  output logic             core_run,
  output logic             context_clear,
  output logic             stack_empty,
  // Cycle steals: host memory port, byte transfer, autobuffer
  input  wire logic [2:0]  steal_req,
  output logic [2:0]       steal_grant,
  // Clock enables and cycle clock
  output logic             proc_clk_en,
  output logic             serial_clk_en,
  output logic             timer_clk_en,
  output logic             cycle_clock_out
);

  if (WAKE_CYCLES < 1 || WAKE_CYCLES > 255) begin : g_chk
    $error("mci_int_lowpower: WAKE_CYCLES must be 1..255");
  end

  localparam logic [MCI_WAKE_CNT_W-1:0] WAKE_LAST = MCI_WAKE_CNT_W'(WAKE_CYCLES - 1);

  // Address match, used by every register select
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Lowest set index wins
  function automatic logic [3:0] pick(input logic [MCI_NUM_SRC-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = MCI_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  mci_state_type               state;
  mci_state_type               next_state;
  logic [MCI_CTRL_W-1:0]       ctrl;
  logic [MCI_NUM_MASK-1:0]     interrupt_mask_reg;
  logic [15:0]                 mode_status_reg;
  logic [MCI_NUM_SRC-1:0]      lat;
  logic [MCI_NUM_SRC-1:0]      next_lat;
  logic [5:0]                  prev_asrt;
  logic [MCI_DIV_W-1:0]        div_code;
  logic [MCI_WAKE_CNT_W-1:0]   wake_cnt;
  logic [3:0]                  irq_id;
  logic                        rst_done;

  // Bus decode
  wire                         acc       = psel & penable;
  wire                         setup     = psel & ~penable;
  wire                         wr        = acc & pwrite;
  wire                         sel_ctrl  = hit(paddr, MCI_OFF_CTRL);
  wire                         sel_mask  = hit(paddr, MCI_OFF_MASK);
  wire                         sel_force = hit(paddr, MCI_OFF_FORCE);
  wire                         sel_vec   = hit(paddr, MCI_OFF_VEC);
  wire                         sel_lpwr  = hit(paddr, MCI_OFF_LPWR);
  wire                         sel_mode_status_reg = hit(paddr, MCI_OFF_MODE_STATUS_REG);
  wire                         mapped    = sel_ctrl | sel_mask | sel_force | sel_vec | sel_lpwr | sel_mode_status_reg;
  wire                         wr_force  = wr & sel_force;
  wire                         wr_lpwr   = wr & sel_lpwr;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // Control fields
  wire                         gie     = ctrl[MCI_CTRL_GIE];
  wire                         sel_edg = ctrl[MCI_CTRL_SEL_EDG];
  wire                         b_edg   = ctrl[MCI_CTRL_B_EDG];
  wire                         a_edg   = ctrl[MCI_CTRL_A_EDG];
  wire                         s2_pins = ctrl[MCI_CTRL_S2_PINS];

  // Shared pins see the flag drive when enabled, else the outside
  wire [3:0]                   pin_in  = {ext_int_selectable_n, ext_int_level_high_n,
                                          ext_int_level_low_n, ext_int_edge_n};
  wire [3:0]                   pin_lvl = (prog_flag_pins_oe & prog_flag_pins_out)
                                       | (~prog_flag_pins_oe & pin_in);
  // Asserted levels: edge, low, high, selectable, shared b, shared a
  wire [5:0]                   asrt    = {~serial_shared_int_a_n, ~serial_shared_int_b_n, ~pin_lvl};
  wire [5:0]                   fall    = asrt & ~prev_asrt;

  // Sticky requests from edges and pulses
  wire [MCI_NUM_SRC-1:0]       hw_set = {
    timer_req,
    s2_pins ? (a_edg & fall[5]) : sp2_rx_req,
    s2_pins ? (b_edg & fall[4]) : sp2_tx_req,
    byte_memory_transfer_req,
    fall[0],
    sp1_rx_req,
    sp1_tx_req,
    1'b0,
    1'b0,
    sel_edg & fall[3],
    pd_int_req};

  // Live requests from level-sensitive inputs
  wire [MCI_NUM_SRC-1:0]       lvl_req = {
    1'b0,
    s2_pins & ~a_edg & asrt[5],
    s2_pins & ~b_edg & asrt[4],
    4'h0,
    asrt[1],
    asrt[2],
    ~sel_edg & asrt[3],
    1'b0};

  wire [MCI_NUM_SRC-1:0]       sw_set  = wr_force ? {pwdata[MCI_NUM_SRC-1:1], 1'b0} : '0;
  wire [MCI_NUM_SRC-1:0]       sw_clr  = wr_force ? pwdata[MCI_FORCE_CLR_LSB +: MCI_NUM_SRC] : '0;
  wire                         taken   = irq_ack & irq_valid;
  wire [MCI_NUM_SRC-1:0]       ack_clr = taken ? (MCI_NUM_SRC'(1) << irq_id) : '0;

  // Set beats clear, so an event during its own clear is kept
  assign next_lat = hw_set | sw_set | (lat & ~(sw_clr | ack_clr));

  wire [MCI_NUM_SRC-1:0]       pend    = lat | lvl_req;
  wire [MCI_NUM_SRC-1:0]       enabled = pend & {interrupt_mask_reg & {MCI_NUM_MASK{gie}}, 1'b1};
  wire                         any_req = |enabled;
  wire [3:0]                   win     = pick(enabled);

  // Shared divider: slow only while idling
  wire                         tick;
  wire                         half;

  mci_clk_div #(
    .CNT_W (7)
  ) u_div (
    .clk      (clk),
    .arst_n   (arst_n),
    .slow     (state == MCI_IDLE),
    .div_code (div_code),
    .tick     (tick),
    .half     (half)
  );

  // Same enable for processor, serial bit clock and timer
  assign proc_clk_en     = tick;
  assign serial_clk_en   = tick;
  assign timer_clk_en    = tick;
  assign cycle_clock_out = half & ~ctrl[MCI_CTRL_CLKODIS];

  // Steals need no instruction flow, so idle grants them too
  assign steal_grant = (state == MCI_RUN || state == MCI_IDLE) ? steal_req : 3'h0;
  assign core_run    = (state == MCI_RUN);

  // Low-power sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      MCI_RUN: begin
        if (wr_lpwr && pwdata[MCI_LP_PD]) begin
          next_state = MCI_PDOWN;
        end else if (wr_lpwr && pwdata[MCI_LP_DIV_LSB +: MCI_DIV_W] <= MCI_DIV_MAX) begin
          next_state = MCI_IDLE;
        end
      end
      MCI_IDLE: begin
        // Wake only on a divided tick, so wake can lag by the divisor
        if (any_req && tick) begin
          next_state = MCI_RUN;
        end
      end
      MCI_PDOWN: begin
        if (pd_wake) begin
          next_state = MCI_WAKE;
        end
      end
      MCI_WAKE: begin
        if (wake_cnt == WAKE_LAST) begin
          next_state = MCI_RUN;
        end
      end
    endcase
  end

  // Recovery counter runs off the free clock; the clock enables stay high every cycle in power down
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_cnt <= '0;
    end else begin
      wake_cnt <= (state == MCI_WAKE) ? wake_cnt + 1'b1 : '0;
    end
  end

  // State, reset ends power down at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= MCI_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Divisor taken when idle is entered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_code <= MCI_DIV_NONE;
    end else if (state == MCI_RUN && next_state == MCI_IDLE) begin
      div_code <= pwdata[MCI_LP_DIV_LSB +: MCI_DIV_W];
    end
  end

  // Context choice shown for one cycle as power down ends
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      context_clear <= 1'b0;
    end else begin
      context_clear <= (state == MCI_WAKE) && (next_state == MCI_RUN) && ctrl[MCI_CTRL_CTXCLR];
    end
  end

  // Stacks held empty through reset and the first edge after it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_done <= 1'b0;
    end else begin
      rst_done <= 1'b1;
    end
  end
  assign stack_empty = ~rst_done;

  // Pending latches and edge history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lat       <= '0;
      prev_asrt <= '0;
    end else begin
      lat       <= next_lat;
      prev_asrt <= asrt;
    end
  end

  // Vector to the core only while running; losers stay pending
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_valid  <= 1'b0;
      irq_vector <= MCI_VEC_RESET;
      irq_id     <= '0;
    end else begin
      irq_valid  <= any_req && next_state == MCI_RUN && !taken;
      irq_vector <= MCI_VEC_TABLE[win*16 +: 16];
      irq_id     <= win;
    end
  end

  // Software registers; reset masks all maskable sources and disables servicing of all but power down
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl               <= MCI_CTRL_RST;
      interrupt_mask_reg <= MCI_MASK_RST;
      mode_status_reg    <= MCI_MODE_STATUS_REG_RST;
    end else if (wr) begin
      if (sel_ctrl) begin
        ctrl <= pwdata[MCI_CTRL_W-1:0];
      end
      if (sel_mask) begin
        interrupt_mask_reg <= pwdata[MCI_NUM_MASK-1:0];
      end
      if (sel_mode_status_reg) begin
        mode_status_reg <= pwdata[15:0];
      end
    end
  end

  // Read data captured in the setup cycle
  wire [31:0] rd_mux =
      sel_ctrl  ? 32'(ctrl) :
      sel_mask  ? 32'(interrupt_mask_reg) :
      sel_force ? {5'h00, lat, 5'h00, pend} :
      sel_vec   ? {11'h000, irq_valid, irq_id, irq_vector} :
      sel_lpwr  ? {27'h0000000, state, div_code} :
      sel_mode_status_reg ? 32'(mode_status_reg) : 32'h00000000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

endmodule // mci_int_lowpower

/* hdl/mci_pkg.sv */
package mci_pkg;

  // Interrupt sources, index order is priority order (0 highest)
  localparam int unsigned MCI_NUM_SRC  = 11;
  localparam int unsigned MCI_NUM_MASK = 10;
  localparam logic [3:0]  MCI_SRC_PD   = 4'h0;
  localparam logic [3:0]  MCI_SRC_SEL  = 4'h1;
  localparam logic [3:0]  MCI_SRC_LHI  = 4'h2;
  localparam logic [3:0]  MCI_SRC_LLO  = 4'h3;
  localparam logic [3:0]  MCI_SRC_S1TX = 4'h4;
  localparam logic [3:0]  MCI_SRC_S1RX = 4'h5;
  localparam logic [3:0]  MCI_SRC_EDGE = 4'h6;
  localparam logic [3:0]  MCI_SRC_BYTE_MEMORY_TRANSFER = 4'h7;
  localparam logic [3:0]  MCI_SRC_S2TX = 4'h8;
  localparam logic [3:0]  MCI_SRC_S2RX = 4'h9;
  localparam logic [3:0]  MCI_SRC_TMR  = 4'hA;

  // Vector table, entry i belongs to source i
  localparam logic [15:0] MCI_VEC_RESET = 16'h0000;
  localparam logic [11*16-1:0] MCI_VEC_TABLE = {
    16'h0028, 16'h0024, 16'h0020, 16'h001C, 16'h0018, 16'h0014,
    16'h0010, 16'h000C, 16'h0008, 16'h0004, 16'h002C};

  // Register byte offsets
  localparam logic [7:0] MCI_OFF_CTRL  = 8'h00;
  localparam logic [7:0] MCI_OFF_MASK  = 8'h04;
  localparam logic [7:0] MCI_OFF_FORCE = 8'h08;
  localparam logic [7:0] MCI_OFF_VEC   = 8'h0C;
  localparam logic [7:0] MCI_OFF_LPWR  = 8'h10;
  localparam logic [7:0] MCI_OFF_MODE_STATUS_REG = 8'h14;

  // Control register fields
  localparam int unsigned MCI_CTRL_GIE     = 0;
  localparam int unsigned MCI_CTRL_SEL_EDG = 1;
  localparam int unsigned MCI_CTRL_B_EDG   = 2;
  localparam int unsigned MCI_CTRL_A_EDG   = 3;
  localparam int unsigned MCI_CTRL_S2_PINS = 4;
  localparam int unsigned MCI_CTRL_CLKODIS = 5;
  localparam int unsigned MCI_CTRL_CTXCLR  = 6;
  localparam int unsigned MCI_CTRL_W       = 7;
  localparam logic [6:0]  MCI_CTRL_RST     = 7'h00;

  // Force register: low half sets, high half clears
  localparam int unsigned MCI_FORCE_CLR_LSB = 16;

  // Low-power register fields
  localparam int unsigned MCI_LP_PD      = 0;
  localparam int unsigned MCI_LP_DIV_LSB = 1;
  localparam int unsigned MCI_DIV_W      = 3;
  localparam logic [2:0]  MCI_DIV_NONE   = 3'h0;
  localparam logic [2:0]  MCI_DIV_MAX    = 3'h4;

  // Reset values
  localparam logic [9:0]  MCI_MASK_RST  = 10'h000;
  localparam logic [15:0] MCI_MODE_STATUS_REG_RST = 16'h0000;

  // Power down recovery, in input clock cycles
  localparam int unsigned MCI_PD_RECOVER_CYCLES = 200;
  localparam int unsigned MCI_WAKE_CNT_W        = 8;

  typedef enum logic [1:0] {
    MCI_RUN   = 2'b00,
    MCI_IDLE  = 2'b01,
    MCI_PDOWN = 2'b10,
    MCI_WAKE  = 2'b11
  } mci_state_type;

endpackage

/* verification/mci_int_lowpower_sva.sv */
// Port-level checks of the interrupt and low-power block
module mci_int_lowpower_sva import mci_pkg::*; (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core side
  input wire logic        irq_valid,
  input wire logic [15:0] irq_vector,
  input wire logic        irq_ack,
  input wire logic        core_run,
  input wire logic        context_clear,
  // Steals and clocks
  input wire logic [2:0]  steal_req,
  input wire logic [2:0]  steal_grant,
  input wire logic        proc_clk_en,
  input wire logic        serial_clk_en,
  input wire logic        timer_clk_en,
  input wire logic        cycle_clock_out
);
  logic gie_q;
  logic cko_dis_q;
  wire  ctrl_wr = psel && penable && pwrite && pready && (paddr == MCI_OFF_CTRL);

  // Shadow of control bits, so checks need no view inside the block
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gie_q     <= 1'b0;
      cko_dis_q <= 1'b0;
    end else if (ctrl_wr) begin
      gie_q     <= pwdata[MCI_CTRL_GIE];
      cko_dis_q <= pwdata[MCI_CTRL_CLKODIS];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_req_up;
    irq_valid && !irq_ack;
  endsequence
  sequence s_req_held;
    irq_valid && $stable(irq_vector);
  endsequence

  a_vector_stands: assert property (s_req_up |=> s_req_held) else $error("vector dropped before ack");
  a_ack_drops: assert property (irq_valid && irq_ack |=> !irq_valid) else $error("request kept after ack");
  a_vector_legal: assert property (irq_valid |-> irq_vector[1:0] == 2'b00 && irq_vector >= 16'h0004
    && irq_vector <= 16'h002C) else $error("vector outside table");
  a_service_off: assert property (!gie_q ##1 !gie_q |-> !irq_valid || irq_vector == 16'h002C)
    else $error("maskable request while servicing off");
  a_steal_run: assert property (core_run |-> steal_grant == steal_req) else $error("steal not granted");
  a_run_full: assert property (core_run |-> proc_clk_en) else $error("clock divided while running");
  a_clocks_same: assert property (proc_clk_en == serial_clk_en && proc_clk_en == timer_clk_en)
    else $error("derived clocks differ");
  a_cycle_clock_out_off: assert property (cko_dis_q ##1 cko_dis_q |-> !cycle_clock_out) else $error("cycle clock on");
  a_ctx_pulse: assert property (context_clear |=> !context_clear) else $error("context clear too long");
  a_refuse_unmapped: assert property (psel && penable && paddr > MCI_OFF_MODE_STATUS_REG |-> pslverr)
    else $error("unmapped access not refused");
endmodule // mci_int_lowpower_sva

bind mci_int_lowpower mci_int_lowpower_sva mci_int_lowpower_sva_inst (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq_valid(irq_valid), .irq_vector(irq_vector),
  .irq_ack(irq_ack), .core_run(core_run), .context_clear(context_clear), .steal_req(steal_req),
  .steal_grant(steal_grant), .proc_clk_en(proc_clk_en), .serial_clk_en(serial_clk_en),
  .timer_clk_en(timer_clk_en), .cycle_clock_out(cycle_clock_out));

/* verification/mci_pin_driver.sv */
// External devices on the six interrupt pins, bit 5 selectable down to bit 0 shared a
module mci_pin_driver (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Which pins are pulled low
  input  wire logic [5:0] hold,
  output logic      [5:0] pins_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pins float to the pull-up level; bench waits for service before a new request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pins_n <= 6'h3F;
    else pins_n <= ~hold;
  end
endmodule // mci_pin_driver

/* verification/tb_mci_int_lowpower.sv */
module tb_mci_int_lowpower import mci_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned WAKE = 4;
  logic clk, arst_n, psel, penable, pwrite, irq_ack, pd_wake, pd_int_req, timer_req;
  logic sp1_tx_req, sp1_rx_req, sp2_tx_req, sp2_rx_req, bmt_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, cnt, k, n;
  logic pready, pslverr, irq_valid, core_run, context_clear, stack_empty;
  logic proc_clk_en, serial_clk_en, timer_clk_en, cycle_clock_out;
  logic [15:0] irq_vector;
  logic [3:0] flag_out, flag_oe;
  logic [2:0] steal_req, steal_grant;
  logic [5:0] hold;
  wire  [5:0] pins_n;
  int n_errors, check_count, cyc;
  logic [5:0] hold_t[6] = '{6'h20, 6'h10, 6'h00, 6'h04, 6'h02, 6'h01};
  logic [3:0] oe_t[6] = '{4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0};
  logic [31:0] ctl_t[6] = '{32'h01, 32'h01, 32'h01, 32'h01, 32'h15, 32'h11};
  logic [15:0] vec_t[6] = '{16'h0004, 16'h0008, 16'h000C, 16'h0018, 16'h0020, 16'h0024};
  logic [15:0] prio_t[6] = '{16'h0010, 16'h0014, 16'h001C, 16'h0020, 16'h0024, 16'h0028};

  mci_pin_driver mci_pin_driver_inst (.clk(clk), .arst_n(arst_n), .hold(hold), .pins_n(pins_n));
  mci_int_lowpower #(.WAKE_CYCLES(WAKE)) mci_int_lowpower_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_int_selectable_n(pins_n[5]), .ext_int_level_high_n(pins_n[4]),
    .ext_int_level_low_n(pins_n[3] & ~(flag_oe[1] & ~flag_out[1])), .ext_int_edge_n(pins_n[2]),
    .serial_shared_int_b_n(pins_n[1]), .serial_shared_int_a_n(pins_n[0]), .prog_flag_pins_out(flag_out),
    .prog_flag_pins_oe(flag_oe), .sp1_tx_req(sp1_tx_req), .sp1_rx_req(sp1_rx_req), .sp2_tx_req(sp2_tx_req),
    .sp2_rx_req(sp2_rx_req), .byte_memory_transfer_req(bmt_req), .timer_req(timer_req),
    .pd_int_req(pd_int_req), .pd_wake(pd_wake), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .irq_ack(irq_ack), .core_run(core_run), .context_clear(context_clear), .stack_empty(stack_empty),
    .steal_req(steal_req), .steal_grant(steal_grant), .proc_clk_en(proc_clk_en),
    .serial_clk_en(serial_clk_en), .timer_clk_en(timer_clk_en), .cycle_clock_out(cycle_clock_out));

  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One APB transfer, entered just after an edge; an idle edge follows so calls may chain
  // Only the hang guard ends a wait for pready, so a stuck slave is counted as a mismatch
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  // Wait for a request, compare its vector, then acknowledge and free the pins together:
  // a level source holds its pin until serviced, else the request drops before the ack
  task automatic take_irq(input logic [15:0] vec);
    while (irq_valid !== 1'b1) @(posedge clk);
    check({16'h0, irq_vector}, {16'h0, vec});
    irq_ack <= 1'b1; hold <= 6'h00; flag_oe <= 4'h0;
    @(posedge clk);
    irq_ack <= 1'b0;
    @(posedge clk);
  endtask

  // Hang guard, far above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    {psel, penable, pwrite, irq_ack, pd_wake, pd_int_req, timer_req} = '0;
    {sp1_tx_req, sp1_rx_req, sp2_tx_req, sp2_rx_req, bmt_req} = '0;
    paddr = '0; pwdata = '0; flag_out = '0; flag_oe = '0; steal_req = '0; hold = '0;
    arst_n = 1'b0;
    repeat (6) @(posedge clk);
    check({31'h0, stack_empty}, 32'h1);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check({31'h0, stack_empty}, 32'h0);
    apb(1'b0, MCI_OFF_CTRL, 0, q); check(q, 32'h0);
    apb(1'b0, MCI_OFF_MASK, 0, q); check(q, 32'h0);
    apb(1'b0, 8'h3C, 0, q); check(q, 32'h0);
    wr(MCI_OFF_MODE_STATUS_REG, 32'hA5C3);
    apb(1'b0, MCI_OFF_MODE_STATUS_REG, 0, q); check(q, 32'hA5C3);
    $display("test reset done");
    // Servicing off: pending kept, nothing vectored except power down
    wr(MCI_OFF_MASK, 32'h3FF);
    timer_req <= 1'b1; @(posedge clk); timer_req <= 1'b0;
    repeat (4) @(posedge clk);
    check({31'h0, irq_valid}, 32'h0);
    apb(1'b0, MCI_OFF_FORCE, 0, q); check({31'h0, q[MCI_SRC_TMR]}, 32'h1);
    wr(MCI_OFF_MASK, 32'h0);
    pd_int_req <= 1'b1; @(posedge clk); pd_int_req <= 1'b0;
    take_irq(16'h002C);
    wr(MCI_OFF_FORCE, 32'h1 << (MCI_FORCE_CLR_LSB + MCI_SRC_TMR));
    $display("test masking done");
    // Six pulse-request sources at once come out in priority order
    wr(MCI_OFF_CTRL, 32'h1); wr(MCI_OFF_MASK, 32'h3FF);
    {sp1_tx_req, sp1_rx_req, bmt_req, sp2_tx_req, sp2_rx_req, timer_req} <= 6'h3F;
    @(posedge clk);
    {sp1_tx_req, sp1_rx_req, bmt_req, sp2_tx_req, sp2_rx_req, timer_req} <= 6'h00;
    foreach (prio_t[i]) take_irq(prio_t[i]);
    // Pins, level and edge modes, and the flag output on a shared pin
    for (int i = 0; i < 6; i++) begin
      wr(MCI_OFF_CTRL, ctl_t[i]);
      hold <= hold_t[i]; flag_oe <= oe_t[i];
      take_irq(vec_t[i]);
    end
    $display("test vectors done");
    // Idle with each divisor, steals granted, wake by timer
    wr(MCI_OFF_CTRL, 32'h1);
    for (int c = 0; c < 5; c++) begin
      n = (c == 0) ? 32'd1 : (32'd8 << c);
      wr(MCI_OFF_LPWR, c << MCI_LP_DIV_LSB);
      repeat (2) @(posedge clk);
      check({31'h0, core_run}, 32'h0);
      cnt = 0;
      repeat (4 * n) begin @(posedge clk); if (proc_clk_en === 1'b1) cnt++; end
      check(cnt, 32'd4);
      steal_req <= 3'h5; @(posedge clk);
      check({29'h0, steal_grant}, 32'h5);
      steal_req <= 3'h0; timer_req <= 1'b1; @(posedge clk); timer_req <= 1'b0;
      k = 0;
      while (core_run !== 1'b1 && k < 300) begin @(posedge clk); k++; end
      check({31'h0, k <= n + 2}, 32'h1);
      take_irq(16'h0028);
    end
    $display("test idle done");
    // Cycle clock out runs, then is disabled
    for (int d = 0; d < 2; d++) begin
      wr(MCI_OFF_CTRL, d << MCI_CTRL_CLKODIS);
      cnt = 0;
      repeat (8) begin @(posedge clk); if (cycle_clock_out === 1'b1) cnt++; end
      check(cnt, d ? 32'd0 : 32'd4);
    end
    $display("test cycle clock done");
    // Power down, wake with context clear, then reset ends a second power down
    wr(MCI_OFF_CTRL, 32'h41); wr(MCI_OFF_LPWR, 32'h1);
    apb(1'b0, MCI_OFF_LPWR, 0, q); check({30'h0, q[4:3]}, 32'h2);
    steal_req <= 3'h7; @(posedge clk);
    check({29'h0, steal_grant}, 32'h0);
    steal_req <= 3'h0;
    repeat (20) @(posedge clk);
    check({31'h0, core_run}, 32'h0);
    pd_wake <= 1'b1; @(posedge clk); pd_wake <= 1'b0;
    k = 0;
    while (core_run !== 1'b1 && k < 300) begin @(posedge clk); k++; end
    check({31'h0, k >= WAKE && k <= WAKE + 2}, 32'h1);
    check({31'h0, context_clear}, 32'h1);
    wr(MCI_OFF_LPWR, 32'h1);
    repeat (4) @(posedge clk);
    arst_n <= 1'b0; @(posedge clk);
    check({31'h0, core_run}, 32'h1);
    arst_n <= 1'b1; repeat (2) @(posedge clk);
    apb(1'b0, MCI_OFF_LPWR, 0, q); check({30'h0, q[4:3]}, 32'h0);
    apb(1'b0, MCI_OFF_MODE_STATUS_REG, 0, q); check(q, 32'h0);
    $display("test power down done");
    end_of_test();
  end
endmodule // tb_mci_int_lowpower
